// ===== reset_cause_pkg.sv
// constants shared by the reset-cause flag register and its event front end
package reset_cause_pkg;

	// register byte addresses on the bus
	localparam logic [7:0] CAUSE_ADDR = 8'h00;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h04;
	localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h08;
	localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h0C;

	// field positions, shared by the cause register and the interrupt registers
	localparam int STACK_OVERFLOW_BIT = 7;
	localparam int STACK_UNDERFLOW_BIT = 6;
	localparam int UNUSED_BIT = 5;
	localparam int WATCHDOG_BIT = 4;
	localparam int PIN_RESET_BIT = 3;
	localparam int RESET_INSTR_BIT = 2;
	localparam int POWER_ON_BIT = 1;
	localparam int BROWNOUT_BIT = 0;

	localparam int FLAG_WIDTH = 8;
	localparam int EVENT_WIDTH = 8;
	localparam int BUS_WIDTH = 32;
	localparam int ADDR_WIDTH = 8;

	// bit 5 is absent everywhere
	localparam logic [7:0] IMPL_MASK = 8'hDF;
	// stack flags 0, watchdog/pin/instruction 1, power-on 0, brown-out 0
	localparam logic [7:0] CAUSE_POWER_ON_VALUE = 8'h1C;
	// watchdog, pin and instruction flags after a brown-out
	localparam logic [7:0] CAUSE_BROWNOUT_SET = 8'h1C;
	// stack flags and brown-out flag cleared by a brown-out
	localparam logic [7:0] CAUSE_BROWNOUT_CLEAR = 8'hC1;
	localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
	localparam logic [31:0] READ_DATA_RESET = 32'h00000000;

	// synchroniser depth ahead of the edge detector
	localparam int SYNC_STAGES = 2;
	// cycles from an event input rising to the flag changing
	localparam int EVENT_LATENCY_CYCLES = 3;
	// cycles from a bus request to its acknowledge
	localparam int ACK_LATENCY_CYCLES = 1;

endpackage

// ===== event_sync.sv
// two-flop synchroniser and rising-edge detector for the reset event lines
`timescale 1ns/1ps
`default_nettype none

module event_sync
	import reset_cause_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [EVENT_WIDTH-1:0] level_in,
	output logic [EVENT_WIDTH-1:0] rise
);

	typedef struct packed {
		logic [EVENT_WIDTH-1:0] meta;
		logic [EVENT_WIDTH-1:0] stable;
		logic [EVENT_WIDTH-1:0] prev;
	} sync_s;

	sync_s state;
	sync_s next_state;

	always_comb begin
		next_state = state;
		next_state.meta = level_in;
		next_state.stable = state.meta;
		next_state.prev = state.stable;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state.meta <= '0;
			state.stable <= '0;
			state.prev <= '0;
		end else begin
			state <= next_state;
		end
	end

	// a line held high yields one pulse, so a long reset counts once
	assign rise = state.stable & ~state.prev;

endmodule

`default_nettype wire

// ===== reset_cause_flags.sv
// reset-cause flag register with wishbone slave and event interrupt
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE1] stack overflow sets bit 7; stays set until firmware writes 0
// [RULE2] stack underflow sets bit 6; stays set until firmware writes 0
// [RULE3] bit 5 absent: reads zero, writes ignored
// [RULE4] watchdog reset clears bit 4; firmware may write it back to 1
// [RULE5] external reset pin clears bit 3; firmware rewrites 1 to re-arm
// [RULE6] reset instruction clears bit 2; stays 0 until firmware writes 1
// [RULE7] power-on clears bit 1; firmware must write 1 to arm detection
// [RULE8] brown-out or power-on clears bit 0; firmware must write 1 afterwards
// [RULE9] power-on/brown-out: stack flags 0, watchdog/pin/instruction flags 1
// [RULE10] power-on and brown-out flags keep their value on other resets
// [RULE11] low-power supply monitor request is ored with brown-out request
// [RULE12] hardware flag update wins over a same-cycle firmware write
module reset_cause_flags
	import reset_cause_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_WIDTH-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [BUS_WIDTH-1:0] dat_i,
	output logic [BUS_WIDTH-1:0] dat_o,
	output logic ack_o,
	input wire logic stack_overflow_event,
	input wire logic stack_underflow_event,
	input wire logic watchdog_timer_reset,
	input wire logic external_reset_pin_n,
	input wire logic reset_instr_event,
	input wire logic power_on_request,
	input wire logic brownout_request,
	input wire logic low_power_supply_monitor,
	output logic [FLAG_WIDTH-1:0] reset_cause,
	output logic irq
);

	typedef struct packed {
		logic [FLAG_WIDTH-1:0] cause;
		logic [FLAG_WIDTH-1:0] status;
		logic [FLAG_WIDTH-1:0] enable;
		logic [BUS_WIDTH-1:0] rdata;
		logic ack;
		logic irq;
	} regs_s;

	regs_s state;
	regs_s next_state;

	logic [EVENT_WIDTH-1:0] event_level;
	logic [EVENT_WIDTH-1:0] event_rise;
	logic [EVENT_WIDTH-1:0] event_hit;
	logic bus_request;
	logic write_lane0;

	// every line is outside this clock, so all go through the synchroniser
	always_comb begin
		event_level = '0;
		event_level[STACK_OVERFLOW_BIT] = stack_overflow_event;
		event_level[STACK_UNDERFLOW_BIT] = stack_underflow_event;
		event_level[WATCHDOG_BIT] = watchdog_timer_reset;
		// pin resets while low
		event_level[PIN_RESET_BIT] = ~external_reset_pin_n;
		event_level[RESET_INSTR_BIT] = reset_instr_event;
		event_level[POWER_ON_BIT] = power_on_request;
		event_level[BROWNOUT_BIT] = brownout_request;
		// spare slot: the monitor gets its own flops, no gate ahead of them
		event_level[UNUSED_BIT] = low_power_supply_monitor;
	end

	event_sync sync_inst (
		.clock(clock),
		.rst(rst),
		.level_in(event_level),
		.rise(event_rise)
	);

	// both supply monitors land on the one brown-out flag
	always_comb begin
		event_hit = event_rise;
		event_hit[BROWNOUT_BIT] = event_rise[BROWNOUT_BIT] | event_rise[UNUSED_BIT]; // see [RULE11]
		event_hit[UNUSED_BIT] = 1'b0;
	end

	function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] adr,
			input logic [ADDR_WIDTH-1:0] target);
		addr_is = (adr == target);
	endfunction

	// read view of one register; clear register and holes read as zero
	function automatic logic [BUS_WIDTH-1:0] read_word(input logic [ADDR_WIDTH-1:0] adr,
			input regs_s cur);
		logic [BUS_WIDTH-1:0] word;
		word = '0;
		if (addr_is(adr, CAUSE_ADDR)) begin
			word[FLAG_WIDTH-1:0] = cur.cause & IMPL_MASK; // see [RULE3]
		end else if (addr_is(adr, IRQ_STATUS_ADDR)) begin
			word[FLAG_WIDTH-1:0] = cur.status & IMPL_MASK;
		end else if (addr_is(adr, IRQ_ENABLE_ADDR)) begin
			word[FLAG_WIDTH-1:0] = cur.enable & IMPL_MASK;
		end
		read_word = word;
	endfunction

	// hardware view of the events, applied after any firmware write
	function automatic logic [FLAG_WIDTH-1:0] apply_events(input logic [FLAG_WIDTH-1:0] flags,
			input logic [EVENT_WIDTH-1:0] ev);
		logic [FLAG_WIDTH-1:0] f;
		f = flags;
		if (ev[STACK_OVERFLOW_BIT]) begin
			f[STACK_OVERFLOW_BIT] = 1'b1; // see [RULE1]
		end
		if (ev[STACK_UNDERFLOW_BIT]) begin
			f[STACK_UNDERFLOW_BIT] = 1'b1; // see [RULE2]
		end
		if (ev[WATCHDOG_BIT]) begin
			f[WATCHDOG_BIT] = 1'b0; // see [RULE4]
		end
		if (ev[PIN_RESET_BIT]) begin
			f[PIN_RESET_BIT] = 1'b0; // see [RULE5]
		end
		if (ev[RESET_INSTR_BIT]) begin
			f[RESET_INSTR_BIT] = 1'b0; // see [RULE6]
		end
		// supply resets override the other causes seen in the same cycle; power-on wins over brown-out
		if (ev[BROWNOUT_BIT]) begin
			f = (f & ~CAUSE_BROWNOUT_CLEAR) | CAUSE_BROWNOUT_SET; // see [RULE8] [RULE9]
		end
		if (ev[POWER_ON_BIT]) begin
			f = CAUSE_POWER_ON_VALUE; // see [RULE7] [RULE8] [RULE9]
		end
		apply_events = f & IMPL_MASK; // see [RULE3]
	endfunction

	assign bus_request = cyc_i & stb_i & ~state.ack;
	// flags sit in byte lane 0; other lanes carry nothing
	assign write_lane0 = bus_request & we_i & sel_i[0];

	always_comb begin
		next_state = state;
		next_state.ack = bus_request;
		next_state.rdata = READ_DATA_RESET;
		if (bus_request & ~we_i) begin
			next_state.rdata = read_word(adr_i, state);
		end

		// firmware write first; the event step below overrides it
		if (write_lane0 & addr_is(adr_i, CAUSE_ADDR)) begin
			next_state.cause = dat_i[FLAG_WIDTH-1:0] & IMPL_MASK; // see [RULE3] [RULE7] [RULE8]
		end
		// power-on and brown-out bits change only on supply events or firmware writes
		next_state.cause = apply_events(next_state.cause, event_hit); // see [RULE10] [RULE12]

		if (write_lane0 & addr_is(adr_i, IRQ_ENABLE_ADDR)) begin
			next_state.enable = dat_i[FLAG_WIDTH-1:0] & IMPL_MASK;
		end
		if (write_lane0 & addr_is(adr_i, IRQ_CLEAR_ADDR)) begin
			next_state.status = state.status & ~dat_i[FLAG_WIDTH-1:0];
		end
		// a new event beats a clear in the same cycle
		next_state.status = (next_state.status | event_hit) & IMPL_MASK; // see [RULE12]

		next_state.irq = |(next_state.status & next_state.enable);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			// block reset acts as a power-on reset
			state.cause <= CAUSE_POWER_ON_VALUE; // see [RULE9]
			state.status <= IRQ_STATUS_RESET;
			state.enable <= IRQ_ENABLE_RESET;
			state.rdata <= READ_DATA_RESET;
			state.ack <= 1'b0;
			state.irq <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign dat_o = state.rdata;
	assign ack_o = state.ack;
	assign reset_cause = state.cause;
	assign irq = state.irq;

endmodule

`default_nettype wire

// ===== reset_cause_flags_asserts.sv
// concurrent checks on the reset-cause register ports
`timescale 1ns/1ps
`default_nettype none
module reset_cause_flags_asserts (
	input wire logic clock,
	input wire logic rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic stack_overflow_event,
	input wire logic watchdog_timer_reset,
	input wire logic external_reset_pin_n,
	input wire logic brownout_request,
	input wire logic low_power_supply_monitor,
	input wire logic [7:0] reset_cause
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("late ack");
	a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_idle_data: assert property (!ack_o |-> dat_o == 32'h00000000) else $error("stray data");
	a_bit5_zero: assert property (reset_cause[5] == 1'b0) else $error("bit 5 set");
	a_reset_value: assert property ($fell(rst) |-> reset_cause == 8'h1C)
		else $error("bad reset value");
	a_ovf_sets: assert property ($rose(stack_overflow_event) |-> ##[3:4] reset_cause[7])
		else $error("overflow flag not set");
	a_wdt_clears: assert property ($rose(watchdog_timer_reset) |-> ##[3:4] !reset_cause[4])
		else $error("watchdog flag not cleared");
	a_pin_clears: assert property ($fell(external_reset_pin_n) |-> ##[3:4] !reset_cause[3])
		else $error("pin flag not cleared");
	a_bor_clears: assert property ($rose(brownout_request || low_power_supply_monitor)
		|-> ##[3:4] !reset_cause[0]) else $error("brown-out flag not cleared");
endmodule
bind reset_cause_flags reset_cause_flags_asserts chk_u (.clock(clock), .rst(rst), .cyc_i(cyc_i),
	.stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .stack_overflow_event(stack_overflow_event),
	.watchdog_timer_reset(watchdog_timer_reset), .external_reset_pin_n(external_reset_pin_n),
	.brownout_request(brownout_request), .low_power_supply_monitor(low_power_supply_monitor),
	.reset_cause(reset_cause));
`default_nettype wire

// ===== tb.sv
// self-checking bench for the reset-cause register
`timescale 1ns/1ps
`default_nettype none
module tb;
	import reset_cause_pkg::*;
	logic clock, rst, cyc, stb, we;
	logic [7:0] adr, ev;
	logic [31:0] dat;
	wire [31:0] dat_o;
	wire ack_o, irq;
	wire [7:0] cause;
	logic [7:0] q[$];
	logic [15:0] seed;
	int n_mismatch, check_count;
	localparam logic [7:0] EXP [8] = '{8'h9F, 8'h5F, 8'hCF, 8'hD7, 8'hDB, 8'h1E, 8'h1E, 8'h1C};
	localparam logic [7:0] STAT [8] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h01, 8'h01, 8'h02};
	reset_cause_flags dut_u (.clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.stack_overflow_event(ev[0]), .stack_underflow_event(ev[1]), .watchdog_timer_reset(ev[2]),
		.external_reset_pin_n(~ev[3]), .reset_instr_event(ev[4]), .brownout_request(ev[5]),
		.low_power_supply_monitor(ev[6]), .power_on_request(ev[7]), .reset_cause(cause), .irq(irq));
	function automatic logic [15:0] xs(input logic [15:0] s);
		s = s ^ (s << 7);
		s = s ^ (s >> 9);
		return s ^ (s << 8);
	endfunction
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h000000, d};
		do @(posedge clock); while (ack_o !== 1'b1);
		{cyc, stb} <= 2'b00;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask
	// held for six cycles so the synchroniser sees one clean edge
	task pulse(input int i);
		@(posedge clock);
		ev[i] <= 1'b1;
		repeat (6) @(posedge clock);
		ev[i] <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	// read data is only valid in the ack cycle
	always @(posedge clock) begin
		if (ack_o === 1'b1 && we === 1'b0) begin
			chk("rdata", dat_o[7:0], q.pop_front());
			chk("rdata_hi", {7'h00, |dat_o[31:8]}, 8'h00);
		end
	end
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		close_out;
	end
	initial begin
		{cyc, stb, we, adr, dat, ev} = '0;
		rst = 1'b1;
		seed = 16'h3D5B;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd(CAUSE_ADDR, 8'h1C);
		rd(8'h10, 8'h00);
		$display("test reset done");
		repeat (3) begin
			seed = xs(seed);
			bus(1'b1, CAUSE_ADDR, seed[7:0]);
			rd(CAUSE_ADDR, seed[7:0] & 8'hDF);
			chk("cause", cause, seed[7:0] & 8'hDF);
		end
		$display("test write done");
		bus(1'b1, IRQ_ENABLE_ADDR, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, CAUSE_ADDR, i < 2 ? 8'h1F : 8'hDF);
			pulse(i);
			rd(CAUSE_ADDR, EXP[i]);
			chk("cause", cause, EXP[i]);
			rd(IRQ_STATUS_ADDR, STAT[i]);
			chk("irq", irq, 8'h01);
			bus(1'b1, IRQ_CLEAR_ADDR, 8'hFF);
			repeat (2) @(posedge clock);
			chk("irq", irq, 8'h00);
		end
		bus(1'b1, IRQ_ENABLE_ADDR, 8'h00);
		pulse(2);
		chk("irq", irq, 8'h00);
		rd(IRQ_STATUS_ADDR, 8'h10);
		$display("test events done");
		bus(1'b1, CAUSE_ADDR, 8'hDF);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd(CAUSE_ADDR, 8'h1C);
		chk("cause", cause, 8'h1C);
		rd(IRQ_ENABLE_ADDR, 8'h00);
		$display("test rerun reset done");
		close_out;
	end
endmodule
`default_nettype wire
